//--- hw/spf_pkg.sv
package spf_pkg;
	// register byte addresses
	localparam logic [31:0] SPF_RX_DATA_ADDR   = 32'hFFFF0A04;
	localparam logic [31:0] SPF_TX_DATA_ADDR   = 32'hFFFF0A08;
	localparam logic [31:0] SPF_BAUD_ADDR      = 32'hFFFF0A0C;
	localparam logic [31:0] SPF_CTRL_ADDR      = 32'hFFFF0A10;
	localparam logic [31:0] SPF_IRQ_STS_ADDR   = 32'hFFFF0A14;
	localparam logic [31:0] SPF_IRQ_MASK_ADDR  = 32'hFFFF0A18;
	localparam logic [31:0] SPF_LEVEL_ADDR     = 32'hFFFF0A1C;
	// reset values
	localparam logic [15:0] SPF_CTRL_RESET     = 16'h0000;
	localparam logic [7:0]  SPF_BAUD_RESET     = 8'h00;
	localparam logic [7:0]  SPF_DATA_RESET     = 8'h00;
	localparam logic [3:0]  SPF_IRQ_RESET      = 4'h0;
	localparam logic [7:0]  SPF_ZERO_FILL      = 8'h00;
	// port_control field positions (match spf_ctrl_s)
	localparam int SPF_CTRL_MODE_LSB = 14;
	localparam int SPF_CTRL_TFLUSH   = 13;
	localparam int SPF_CTRL_RFLUSH   = 12;
	localparam int SPF_CTRL_CONT     = 11;
	localparam int SPF_CTRL_LOOP     = 10;
	localparam int SPF_CTRL_MISO_EN  = 9;
	localparam int SPF_CTRL_OVWR     = 8;
	localparam int SPF_CTRL_ZFILL    = 7;
	localparam int SPF_CTRL_TRIG     = 6;
	localparam int SPF_CTRL_LSBF     = 5;
	localparam int SPF_CTRL_WOR      = 4;
	localparam int SPF_CTRL_CPOL     = 3;
	localparam int SPF_CTRL_CPHA     = 2;
	localparam int SPF_CTRL_MASTER   = 1;
	localparam int SPF_CTRL_EN       = 0;
	// interrupt status bit positions
	localparam int SPF_IRQ_TX  = 0;
	localparam int SPF_IRQ_RX  = 1;
	localparam int SPF_IRQ_OVF = 2;
	localparam int SPF_IRQ_UNF = 3;
	// timing and sizes
	localparam int SPF_FIFO_DEPTH   = 4;
	localparam int SPF_HALF_PER_BYTE = 16;
	localparam int SPF_STALL_HALVES = 2;

	typedef struct packed {
		logic [1:0] irq_threshold_mode;
		logic       tx_fifo_flush;
		logic       rx_fifo_flush;
		logic       continuous_transfer;
		logic       loopback_enable;
		logic       miso_enable;
		logic       rx_overwrite;
		logic       zero_fill_enable;
		logic       transfer_trigger_mode;
		logic       lsb_first;
		logic       wired_or;
		logic       cpol;
		logic       cpha;
		logic       master;
		logic       enable;
	} spf_ctrl_s;

	// synchronised pin levels
	typedef struct packed {
		logic cs_n;
		logic miso;
		logic mosi;
		logic sclk;
	} spf_pins_s;

	typedef enum logic [1:0] {
		SPF_IDLE,
		SPF_XFER,
		SPF_STALL
	} spf_state_e;
endpackage

//--- hw/spf_spi_fifo_control.sv
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module spf_spi_fifo_control
	import spf_pkg::*;
#(
	parameter int DEPTH = SPF_FIFO_DEPTH
) (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        ce_in,
	input  wire logic [31:0] avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	output logic             irq_out,
	input  wire logic        sclk_in,
	output logic             sclk_out,
	output logic             sclk_oe_out,
	input  wire logic        mosi_in,
	output logic             mosi_out,
	output logic             mosi_oe_out,
	input  wire logic        miso_in,
	output logic             miso_out,
	output logic             miso_oe_out,
	input  wire logic        cs_n_in,
	output logic             cs_n_out,
	output logic             cs_n_oe_out
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	// thresholds reach four bytes, pointers wrap by overflow
	if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("DEPTH must be a power of two of at least 4");
	end

	// true when a fifo level exceeds mode, i.e. holds mode+1 bytes
	function automatic logic thr_met(input logic [CW-1:0] n, input logic [1:0] m);
		thr_met = n > CW'(m);
	endfunction

	// ---------------- bus side state ----------------
	logic [15:0] ctrl_q, ctrl_d;          // port_control
	logic [7:0]  baud_q, baud_d;          // baud_select
	logic [3:0]  mask_q, mask_d;          // interrupt mask
	logic        ack_q, ack_d;            // second cycle of an access
	logic [31:0] rdata_q, rdata_d;        // registered read data
	spf_ctrl_s   c;                       // decoded control
	logic        req;                     // request present
	logic        acc;                     // request accepted this edge
	logic        tx_wr;                   // accepted tx_data write
	logic        rx_rd;                   // accepted rx_data read
	logic [3:0]  sts_clr;                 // write-one-to-clear bits

	// ---------------- engine state ----------------
	logic [7:0]    txm_q [DEPTH];         // tx fifo storage
	logic [7:0]    txm_d [DEPTH];
	logic [7:0]    rxm_q [DEPTH];         // rx fifo storage
	logic [7:0]    rxm_d [DEPTH];
	logic [PW-1:0] tx_rp_q, tx_rp_d;      // tx head index
	logic [PW-1:0] rx_rp_q, rx_rp_d;      // rx head index
	logic [CW-1:0] tx_n_q, tx_n_d;        // tx valid bytes
	logic [CW-1:0] rx_n_q, rx_n_d;        // rx valid bytes
	spf_state_e    st_q, st_d;            // master sequencer
	logic [7:0]    div_q, div_d;          // half period divider
	logic [4:0]    ph_q, ph_d;            // half periods in byte
	logic [3:0]    bits_q, bits_d;        // bits sampled
	logic [7:0]    txsh_q, txsh_d;        // transmit shifter
	logic [7:0]    rxsh_q, rxsh_d;        // receive shifter
	logic [7:0]    last_q, last_d;        // last byte shifted out
	logic          cs_q, cs_d;            // master chip select, low active
	logic          sclkl_q, sclkl_d;      // master clock, before polarity
	logic          pend_q, pend_d;        // start requested by rx read
	logic          keep_q, keep_d;        // master continues after byte
	logic [1:0]    sent_q, sent_d;        // bytes sent toward tx irq
	logic [3:0]    sts_q, sts_d;          // sticky interrupt status
	spf_pins_s     s1_q, s2_q, s3_q;      // pin synchroniser stages
	spf_pins_s     filt_q, filt_d;        // accepted pin levels

	// engine temporaries
	logic          slave_act, tick, lead, trail, smp, shf, done;
	logic          obit, bit_in, ld, go, slave_start;
	logic [7:0]    nb, rnew;
	logic [3:0]    sts_set;

	assign c = spf_ctrl_s'(ctrl_q);
	assign req = avs_read_in | avs_write_in;
	assign acc = req & ack_q & ce_in;
	// one wait cycle per access; frozen clock enable keeps the wait
	assign avs_waitrequest_out = req & ~(ack_q & ce_in);
	assign avs_readdata_out = rdata_q;
	assign tx_wr = acc & avs_write_in & avs_byteenable_in[0]
		& (avs_address_in == SPF_TX_DATA_ADDR);
	assign rx_rd = acc & avs_read_in & (avs_address_in == SPF_RX_DATA_ADDR);

	// register decode and read mux
	always_comb begin
		ctrl_d  = ctrl_q;
		baud_d  = baud_q;
		mask_d  = mask_q;
		sts_clr = 4'h0;
		rdata_d = rdata_q;
		ack_d   = req & ~ack_q;
		if (acc && avs_write_in) begin
			case (avs_address_in)
				SPF_CTRL_ADDR: begin
					if (avs_byteenable_in[0]) ctrl_d[7:0] = avs_writedata_in[7:0];
					if (avs_byteenable_in[1]) ctrl_d[15:8] = avs_writedata_in[15:8];
				end
				SPF_BAUD_ADDR: begin
					if (avs_byteenable_in[0]) baud_d = avs_writedata_in[7:0];
				end
				SPF_IRQ_MASK_ADDR: begin
					if (avs_byteenable_in[0]) mask_d = avs_writedata_in[3:0];
				end
				SPF_IRQ_STS_ADDR: begin
					if (avs_byteenable_in[0]) sts_clr = avs_writedata_in[3:0];
				end
				default: begin
					// unmapped or read-only: write ignored
				end
			endcase
		end
		// data captured in the wait cycle, stands while waitrequest is low
		if (avs_read_in && !ack_q) begin
			case (avs_address_in)
				SPF_RX_DATA_ADDR:  rdata_d = {24'h000000, rxm_q[rx_rp_q]};
				SPF_BAUD_ADDR:     rdata_d = {24'h000000, baud_q};
				SPF_CTRL_ADDR:     rdata_d = {16'h0000, ctrl_q};
				SPF_IRQ_STS_ADDR:  rdata_d = {28'h0000000, sts_q};
				SPF_IRQ_MASK_ADDR: rdata_d = {28'h0000000, mask_q};
				SPF_LEVEL_ADDR:    rdata_d = {16'h0000, 8'(tx_n_q), 8'(rx_n_q)};
				default:           rdata_d = 32'h00000000;
			endcase
		end
	end

	// bus side registers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ctrl_q  <= SPF_CTRL_RESET;
			baud_q  <= SPF_BAUD_RESET;
			mask_q  <= SPF_IRQ_RESET;
			ack_q   <= 1'b0;
			rdata_q <= 32'h00000000;
		end else if (ce_in) begin
			ctrl_q  <= ctrl_d;
			baud_q  <= baud_d;
			mask_q  <= mask_d;
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	// pin synchroniser: three stages, second and third must agree
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s1_q <= 4'h8;
			s2_q <= 4'h8;
			s3_q <= 4'h8;
		end else if (ce_in) begin
			s1_q <= {cs_n_in, miso_in, mosi_in, sclk_in};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// serial engine, fifos and interrupt status
	always_comb begin
		txm_d   = txm_q;
		rxm_d   = rxm_q;
		tx_rp_d = tx_rp_q;
		rx_rp_d = rx_rp_q;
		tx_n_d  = tx_n_q;
		rx_n_d  = rx_n_q;
		st_d    = st_q;
		div_d   = div_q;
		ph_d    = ph_q;
		bits_d  = bits_q;
		txsh_d  = txsh_q;
		rxsh_d  = rxsh_q;
		last_d  = last_q;
		cs_d    = cs_q;
		sclkl_d = sclkl_q;
		pend_d  = pend_q;
		keep_d  = keep_q;
		sent_d  = sent_q;
		sts_set = 4'h0;
		ld      = 1'b0;
		go      = keep_q;
		nb      = last_q;
		// filter: accept a level once stages two and three agree
		filt_d  = filt_q;
		for (int i = 0; i < 4; i++) begin
			if (s2_q[i] == s3_q[i]) filt_d[i] = s3_q[i];
		end
		slave_act   = c.enable & ~c.master & ~filt_q.cs_n;
		slave_start = c.enable & ~c.master & filt_q.cs_n & ~filt_d.cs_n;
		tick = (st_q == SPF_XFER) && (div_q == baud_q);
		if (c.master) begin
			lead  = tick & ~ph_q[0];
			trail = tick & ph_q[0];
		end else begin
			lead  = slave_act & (filt_d.sclk != filt_q.sclk) & (filt_d.sclk != c.cpol);
			trail = slave_act & (filt_d.sclk != filt_q.sclk) & (filt_d.sclk == c.cpol);
		end
		smp  = c.cpha ? trail : lead;
		shf  = c.cpha ? lead : trail;
		obit = c.lsb_first ? txsh_q[0] : txsh_q[7];
		// loopback returns our own output bit instead of the pin
		if (c.loopback_enable) bit_in = obit;
		else if (c.master) bit_in = filt_q.miso;
		else bit_in = filt_q.mosi;
		rnew = c.lsb_first ? {bit_in, rxsh_q[7:1]} : {rxsh_q[6:0], bit_in};
		done = smp && (bits_q == 4'h7);

		// software pops the rx head; read-trigger mode requests a byte
		if (rx_rd && rx_n_q != '0) begin
			rx_rp_d = rx_rp_q + PW'(1);
			rx_n_d  = rx_n_q - CW'(1);
		end
		if (rx_rd && !c.transfer_trigger_mode) pend_d = 1'b1;
		// software push; dropped while flushing or full
		if (tx_wr && !c.tx_fifo_flush && tx_n_q != FULL) begin
			txm_d[tx_rp_q + PW'(tx_n_q)] = avs_writedata_in[7:0];
			tx_n_d = tx_n_q + CW'(1);
		end

		// shifters
		if (smp) begin
			rxsh_d = rnew;
			bits_d = bits_q + 4'h1;
		end
		if (shf && bits_q != 4'h0) begin
			txsh_d = c.lsb_first ? {1'b0, txsh_q[7:1]} : {txsh_q[6:0], 1'b0};
		end
		if (done) begin
			bits_d = 4'h0;
			// received byte, unless incoming data is being ignored
			if (!c.rx_fifo_flush) begin
				if (rx_n_d != FULL) begin
					rxm_d[rx_rp_q + PW'(rx_n_q)] = rnew;
					rx_n_d = rx_n_d + CW'(1);
					if (!c.transfer_trigger_mode && thr_met(rx_n_d, c.irq_threshold_mode))
						sts_set[SPF_IRQ_RX] = 1'b1;
				end else begin
					sts_set[SPF_IRQ_OVF] = 1'b1;
					if (c.rx_overwrite) rxm_d[rx_rp_q + PW'(rx_n_q) - PW'(1)] = rnew;
				end
			end
			// count bytes sent toward the tx interrupt
			if (c.transfer_trigger_mode) begin
				if (sent_q == c.irq_threshold_mode) begin
					sent_d = 2'b00;
					sts_set[SPF_IRQ_TX] = 1'b1;
				end else begin
					sent_d = sent_q + 2'b01;
				end
			end
			// slaves reload at once; masters only when continuing
			go = c.continuous_transfer && tx_n_q != '0 && !c.tx_fifo_flush;
			keep_d = go;
			ld = ~c.master | go;
		end
		if (slave_start) begin
			ld = 1'b1;
			bits_d = 4'h0;
		end

		// master sequencer
		case (st_q)
			SPF_IDLE: begin
				cs_d = 1'b1;
				sclkl_d = 1'b0;
				if (c.enable && c.master && (c.transfer_trigger_mode ? tx_n_q != '0 : pend_q)) begin
					st_d = SPF_XFER;
					cs_d = 1'b0;
					ld = 1'b1;
					pend_d = 1'b0;
					div_d = 8'h00;
					ph_d = 5'd0;
					bits_d = 4'h0;
					keep_d = 1'b0;
				end
			end
			SPF_XFER: begin
				if (tick) begin
					div_d = 8'h00;
					sclkl_d = ~sclkl_q;
					if (ph_q == 5'(SPF_HALF_PER_BYTE - 1)) begin
						ph_d = 5'd0;
						if (!go) begin
							// single byte or fifo drained: release and stall
							st_d = SPF_STALL;
							cs_d = 1'b1;
						end
					end else begin
						ph_d = ph_q + 5'd1;
					end
				end else begin
					div_d = div_q + 8'h01;
				end
			end
			SPF_STALL: begin
				// one serial clock idle before the next byte may start
				if (div_q == baud_q) begin
					div_d = 8'h00;
					ph_d = ph_q + 5'd1;
					if (ph_q == 5'(SPF_STALL_HALVES - 1)) st_d = SPF_IDLE;
				end else begin
					div_d = div_q + 8'h01;
				end
			end
			default: st_d = SPF_IDLE;
		endcase
		// disabling or leaving master mode aborts the sequence
		if (!c.enable || !c.master) begin
			st_d = SPF_IDLE;
			cs_d = 1'b1;
		end

		// next byte: fifo head, else zero fill or repeat
		if (ld) begin
			if (tx_n_q != '0) begin
				nb = txm_q[tx_rp_q];
				tx_rp_d = tx_rp_q + PW'(1);
				tx_n_d = tx_n_d - CW'(1);
			end else begin
				nb = c.zero_fill_enable ? SPF_ZERO_FILL : last_q;
				if (!c.tx_fifo_flush) sts_set[SPF_IRQ_UNF] = 1'b1;
			end
			txsh_d = nb;
			last_d = nb;
		end

		// level-held flushes win over any push or pop
		if (c.tx_fifo_flush) begin
			tx_n_d = '0;
			tx_rp_d = '0;
		end
		if (c.rx_fifo_flush) begin
			rx_n_d = '0;
			rx_rp_d = '0;
			// no interrupt of any kind while incoming data is ignored
			sts_set = 4'h0;
		end
		// set beats a clear arriving in the same cycle
		sts_d = (sts_q & ~sts_clr) | sts_set;
	end

	// engine registers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				txm_q[i] <= SPF_DATA_RESET;
				rxm_q[i] <= SPF_DATA_RESET;
			end
			tx_rp_q <= '0;
			rx_rp_q <= '0;
			tx_n_q  <= '0;
			rx_n_q  <= '0;
			st_q    <= SPF_IDLE;
			div_q   <= 8'h00;
			ph_q    <= 5'd0;
			bits_q  <= 4'h0;
			txsh_q  <= SPF_DATA_RESET;
			rxsh_q  <= SPF_DATA_RESET;
			last_q  <= SPF_DATA_RESET;
			cs_q    <= 1'b1;
			sclkl_q <= 1'b0;
			pend_q  <= 1'b0;
			keep_q  <= 1'b0;
			sent_q  <= 2'b00;
			sts_q   <= SPF_IRQ_RESET;
			filt_q  <= 4'h8;
		end else if (ce_in) begin
			txm_q   <= txm_d;
			rxm_q   <= rxm_d;
			tx_rp_q <= tx_rp_d;
			rx_rp_q <= rx_rp_d;
			tx_n_q  <= tx_n_d;
			rx_n_q  <= rx_n_d;
			st_q    <= st_d;
			div_q   <= div_d;
			ph_q    <= ph_d;
			bits_q  <= bits_d;
			txsh_q  <= txsh_d;
			rxsh_q  <= rxsh_d;
			last_q  <= last_d;
			cs_q    <= cs_d;
			sclkl_q <= sclkl_d;
			pend_q  <= pend_d;
			keep_q  <= keep_d;
			sent_q  <= sent_d;
			sts_q   <= sts_d;
			filt_q  <= filt_d;
		end
	end

	// pins; wired-or mode only ever pulls data lines low
	assign irq_out     = |(sts_q & mask_q);
	assign sclk_out    = sclkl_q ^ c.cpol;
	assign sclk_oe_out = c.enable & c.master;
	assign cs_n_out    = cs_q;
	assign cs_n_oe_out = c.enable & c.master;
	assign mosi_out    = obit;
	assign mosi_oe_out = c.enable & c.master & (~c.wired_or | ~obit);
	assign miso_out    = obit;
	assign miso_oe_out = slave_act & c.miso_enable & (~c.wired_or | ~obit);
endmodule

//--- sim/spf_spi_fifo_control_assertions.sv
`timescale 1ns/1ps
// outside view of the block: register bus plus master pins
module spf_chk
	import spf_pkg::*;
#(
	parameter int DEPTH = SPF_FIFO_DEPTH
) (
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic [31:0] avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic        avs_waitrequest_out,
	input wire logic        irq_out,
	input wire logic        sclk_out,
	input wire logic        cs_n_out,
	input wire logic        cs_n_oe_out,
	input wire logic        mosi_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic [15:0] ctl_q, ctl_d;   // shadow of port_control
	logic [7:0]  baud_q, baud_d; // shadow of baud_select
	logic [3:0]  mask_q, mask_d; // shadow of the irq mask
	logic        sclk_q;         // serial clock one cycle ago
	logic [7:0]  hcnt_q, hcnt_d; // cycles since last serial clock edge
	logic        seen_q, seen_d; // an edge already seen in this frame
	logic [4:0]  edg_q, edg_d;   // rising serial edges in this frame
	logic        take;           // write accepted this cycle
	logic        chg;            // serial clock moved this cycle
	assign take = avs_write_in && !avs_waitrequest_out;
	assign chg  = sclk_out != sclk_q;
	// shadows only follow accepted writes, so a stalled write changes nothing
	always_comb begin
		ctl_d  = ctl_q;
		baud_d = baud_q;
		mask_d = mask_q;
		if (take && avs_address_in == SPF_CTRL_ADDR) begin
			ctl_d = avs_writedata_in[15:0];
		end
		if (take && avs_address_in == SPF_BAUD_ADDR) begin
			baud_d = avs_writedata_in[7:0];
		end
		if (take && avs_address_in == SPF_IRQ_MASK_ADDR) begin
			mask_d = avs_writedata_in[3:0];
		end
		hcnt_d = chg ? 8'h00 : hcnt_q + 8'h01;
		seen_d = !cs_n_out && (seen_q || chg);
		edg_d  = cs_n_out ? 5'h00 : edg_q + 5'(chg && sclk_out);
	end
	// helper registers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ctl_q  <= 16'h0000;
			baud_q <= 8'h00;
			mask_q <= 4'h0;
			sclk_q <= 1'b0;
			hcnt_q <= 8'h00;
			seen_q <= 1'b0;
			edg_q  <= 5'h00;
		end else begin
			ctl_q  <= ctl_d;
			baud_q <= baud_d;
			mask_q <= mask_d;
			sclk_q <= sclk_out;
			hcnt_q <= hcnt_d;
			seen_q <= seen_d;
			edg_q  <= edg_d;
		end
	end
	chk_bus_answer: assert property ($rose(avs_read_in || avs_write_in) |->
		avs_waitrequest_out ##1 !avs_waitrequest_out) else $error("bus answer late");
	chk_cs_stall: assert property ($rose(cs_n_out) && cs_n_oe_out |-> cs_n_out[*2])
		else $error("no stall after frame");
	chk_frame_min: assert property ($fell(cs_n_out) && cs_n_oe_out |-> !cs_n_out[*8])
		else $error("frame too short");
	chk_frame_bits: assert property ($rose(cs_n_out) && cs_n_oe_out |->
		seen_q && edg_q[2:0] == 3'h0) else $error("frame not whole bytes");
	chk_half_period: assert property ($changed(sclk_out) && seen_q && !cs_n_out |->
		hcnt_q == baud_q) else $error("half period wrong");
	chk_zero_fill: assert property ($fell(cs_n_out) && cs_n_oe_out && ctl_q[13] && ctl_q[7]
		&& $past(ctl_q[13], 3) |-> !mosi_out[*8]) else $error("flush sent nonzero");
	chk_tx_flushed: assert property (avs_read_in && !avs_waitrequest_out && ctl_q[13] &&
		$past(ctl_q[13], 3) && avs_address_in == SPF_LEVEL_ADDR |->
		avs_readdata_out[15:8] == 8'h00) else $error("tx count not held at zero");
	chk_rx_flushed: assert property (avs_read_in && !avs_waitrequest_out && ctl_q[12] &&
		$past(ctl_q[12], 3) && avs_address_in == SPF_LEVEL_ADDR |->
		avs_readdata_out[7:0] == 8'h00) else $error("rx count not held at zero");
	chk_read_start: assert property (avs_read_in && !avs_waitrequest_out && ctl_q[12] &&
		!ctl_q[6] && ctl_q[1:0] == 2'h3 && avs_address_in == SPF_RX_DATA_ADDR |->
		##[1:600] !cs_n_out) else $error("rx read started nothing");
	chk_irq_masked: assert property (mask_q == 4'h0 |-> !irq_out) else $error("irq while masked");
endmodule
bind spf_spi_fifo_control spf_chk #(.DEPTH(DEPTH)) u_chk (.clk_in(clk_in), .rst_in(rst_in),
	.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out), .sclk_out(sclk_out),
	.cs_n_out(cs_n_out), .cs_n_oe_out(cs_n_oe_out), .mosi_out(mosi_out));

//--- sim/spf_peer.sv
`timescale 1ns/1ps
// far-side peer: slave while the block masters, master on request
module spf_peer (
	input  wire logic clk_in,
	input  wire logic sclk_out,
	input  wire logic sclk_oe_out,
	input  wire logic cs_n_out,
	input  wire logic cs_n_oe_out,
	input  wire logic mosi_out,
	input  wire logic mosi_oe_out,
	input  wire logic miso_out,
	input  wire logic miso_oe_out,
	output logic      sclk_w,
	output logic      cs_w,
	output logic      mosi_w,
	output logic      miso_w
);
	localparam logic [7:0] RESP = 8'h3C; // reply byte as a slave
	logic       m_sclk = 1'b0;  // own serial clock, still between frames
	logic       m_cs   = 1'b1;  // own chip select
	logic       m_mosi = 1'b0;  // own data out
	logic       tgl    = 1'b0;  // filler for an unselected data line
	logic [7:0] sh     = RESP;  // slave shifter
	logic [7:0] got    = 8'h00; // last byte seen on the data line
	// wire levels: whoever has its enable up drives
	assign sclk_w = sclk_oe_out ? sclk_out : m_sclk;
	assign cs_w   = cs_n_oe_out ? cs_n_out : m_cs;
	assign mosi_w = mosi_oe_out ? mosi_out : m_mosi;
	assign miso_w = miso_oe_out ? miso_out : (cs_w ? tgl : sh[7]);
	// deselected line changes every cycle so a stale bit never passes
	always @(posedge clk_in) tgl <= ~tgl;
	// slave shifter: loads on select, moves on the trailing edge
	always @(negedge cs_w) sh <= RESP;
	always @(negedge sclk_w) if (!cs_w) sh <= {sh[6:0], 1'b0};
	// record what the other end put on the wire, msb first
	always @(posedge sclk_w) if (!cs_w) got <= {got[6:0], cs_n_oe_out ? mosi_w : miso_w};
	// one byte as master, 400 ns serial period, edges 13 ns after a clk_in rising edge
	task automatic send(input logic [7:0] b);
		@(posedge clk_in);
		#13;
		m_cs = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			m_mosi = b[i];
			#200 m_sclk = 1'b1;
			#200 m_sclk = 1'b0;
		end
		#200 m_cs = 1'b1;
		m_mosi = ~m_mosi; // released line shows the inverse of the last bit
	endtask
endmodule

//--- sim/spf_spi_fifo_control_test.sv
`timescale 1ns/1ps
// register-level test of the spi fifo control block
module spf_spi_fifo_control_test
	import spf_pkg::*;
;
	localparam logic [31:0] ME = 32'h0003; // enable plus master
	localparam logic [31:0] TG = 32'h0040; // start on tx write
	localparam logic [31:0] ZF = 32'h0080; // zero fill
	localparam logic [31:0] LP = 32'h0400; // loopback
	localparam logic [31:0] CT = 32'h0800; // continuous
	localparam logic [31:0] FL = 32'h3000; // both flushes
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        rd     = 1'b0;
	logic        we     = 1'b0;
	logic [31:0] adr    = 32'h0;
	logic [31:0] wd     = 32'h0;
	logic [31:0] q;
	wire  [31:0] rdata;
	wire         wreq, irq_out, sclk_out, sclk_oe, cs_n_out, cs_n_oe;
	wire         mosi_out, mosi_oe, miso_out, miso_oe, sclk_w, cs_w, mosi_w, miso_w;
	int          mismatches = 0;
	int          n_checks   = 0;
	int          falls      = 0;
	int          f0;
	spf_spi_fifo_control DUT (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(we), .avs_writedata_in(wd),
		.avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
		.irq_out(irq_out), .sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe_out(sclk_oe),
		.mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_out(mosi_oe), .miso_in(miso_w),
		.miso_out(miso_out), .miso_oe_out(miso_oe), .cs_n_in(cs_w), .cs_n_out(cs_n_out),
		.cs_n_oe_out(cs_n_oe));
	spf_peer u_peer (.clk_in(clk_in), .sclk_out(sclk_out), .sclk_oe_out(sclk_oe),
		.cs_n_out(cs_n_out), .cs_n_oe_out(cs_n_oe), .mosi_out(mosi_out), .mosi_oe_out(mosi_oe),
		.miso_out(miso_out), .miso_oe_out(miso_oe), .sclk_w(sclk_w), .cs_w(cs_w),
		.mosi_w(mosi_w), .miso_w(miso_w));
	// 50 ns system clock
	initial begin
		forever #25 clk_in = ~clk_in;
	end
	// frames started by the block
	always @(negedge cs_n_out) falls++;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// one bus access; request held until waitrequest is seen low at a rising edge
	task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		rd  <= !w;
		we  <= w;
		adr <= a;
		wd  <= d;
		do begin
			@(posedge clk_in);
			n++;
		end while (wreq !== 1'b0 && n < 100);
		if (n >= 100) begin
			mismatches++;
		end
		// data taken at the accepting edge, release right after it
		q = rdata;
		rd <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask
	task automatic rdc(input logic [31:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	// link quiet: chip select high for 200 cycles in a row
	task automatic idle();
		int n, h;
		n = 0;
		h = 0;
		while (h < 200 && n < 20000) begin
			@(negedge clk_in);
			n++;
			h = (cs_n_out === 1'b1) ? h + 1 : 0;
		end
		if (n >= 20000) begin
			mismatches++;
		end
	endtask
	task automatic stop_test();
		if (mismatches == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// hang guard, well beyond the expected run
	initial begin
		#1000000;
		mismatches++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		rdc(SPF_RX_DATA_ADDR, 32'h0);
		rdc(SPF_BAUD_ADDR, 32'h0);
		rdc(SPF_CTRL_ADDR, 32'h0);
		rdc(32'hFFFF0A20, 32'h0);
		wr(SPF_RX_DATA_ADDR, 32'hFF);
		rdc(SPF_RX_DATA_ADDR, 32'h0);
		wr(SPF_BAUD_ADDR, 32'h07);
		rdc(SPF_BAUD_ADDR, 32'h07);
		wr(SPF_IRQ_MASK_ADDR, 32'h1);
		// every threshold code: m bytes stay quiet, byte m+1 raises tx irq
		for (int m = 0; m < 4; m++) begin
			wr(SPF_CTRL_ADDR, (32'(m) << 14) | CT | LP | TG | ME);
			wr(SPF_IRQ_STS_ADDR, 32'hF);
			f0 = falls;
			for (int i = 0; i < m; i++) wr(SPF_TX_DATA_ADDR, 32'hA0 + 32'(i));
			idle();
			acc(1'b0, SPF_IRQ_STS_ADDR, 32'h0);
			chk(q & 32'h1, 32'h0);
			wr(SPF_TX_DATA_ADDR, 32'hA0 + 32'(m));
			idle();
			acc(1'b0, SPF_IRQ_STS_ADDR, 32'h0);
			chk(q & 32'h1, 32'h1);
			chk({31'h0, irq_out}, 32'h1);
			chk(32'(falls - f0), (m > 0) ? 32'h2 : 32'h1);
			for (int i = 0; i <= m; i++) rdc(SPF_RX_DATA_ADDR, 32'hA0 + 32'(i));
		end
		wr(SPF_IRQ_STS_ADDR, 32'h1);
		// the clear lands at the accepting edge, look one edge later
		@(posedge clk_in);
		chk({31'h0, irq_out}, 32'h0);
		// single-byte frames, one per queued byte
		wr(SPF_CTRL_ADDR, LP | TG | ME);
		f0 = falls;
		wr(SPF_TX_DATA_ADDR, 32'h5A);
		wr(SPF_TX_DATA_ADDR, 32'hA5);
		idle();
		chk(32'(falls - f0), 32'h2);
		rdc(SPF_RX_DATA_ADDR, 32'h5A);
		rdc(SPF_RX_DATA_ADDR, 32'hA5);
		// loopback off: the peer answers on the data-in line
		wr(SPF_CTRL_ADDR, TG | ME);
		wr(SPF_TX_DATA_ADDR, 32'h66);
		idle();
		rdc(SPF_RX_DATA_ADDR, 32'h3C);
		chk({24'h0, u_peer.got}, 32'h66);
		// read-started transfers with an empty tx fifo
		wr(SPF_CTRL_ADDR, LP | ME);
		wr(SPF_IRQ_MASK_ADDR, 32'h2);
		wr(SPF_IRQ_STS_ADDR, 32'hF);
		acc(1'b0, SPF_RX_DATA_ADDR, 32'h0);
		idle();
		acc(1'b0, SPF_IRQ_STS_ADDR, 32'h0);
		chk(q & 32'h2, 32'h2);
		chk({31'h0, irq_out}, 32'h1);
		rdc(SPF_RX_DATA_ADDR, 32'h66);
		idle();
		wr(SPF_IRQ_STS_ADDR, 32'h2);
		@(posedge clk_in);
		chk({31'h0, irq_out}, 32'h0);
		wr(SPF_CTRL_ADDR, ZF | LP | ME);
		rdc(SPF_RX_DATA_ADDR, 32'h66);
		idle();
		rdc(SPF_RX_DATA_ADDR, 32'h0);
		idle();
		// both fifos flushed: writes dropped, reads still start, nothing received
		wr(SPF_CTRL_ADDR, FL | ZF | LP | ME);
		wr(SPF_IRQ_STS_ADDR, 32'hF);
		wr(SPF_TX_DATA_ADDR, 32'h77);
		rdc(SPF_LEVEL_ADDR, 32'h0);
		f0 = falls;
		acc(1'b0, SPF_RX_DATA_ADDR, 32'h0);
		idle();
		chk(32'(falls - f0), 32'h1);
		rdc(SPF_LEVEL_ADDR, 32'h0);
		acc(1'b0, SPF_IRQ_STS_ADDR, 32'h0);
		chk(q & 32'h2, 32'h0);
		chk({31'h0, irq_out}, 32'h0);
		wr(SPF_CTRL_ADDR, LP | TG | ME);
		wr(SPF_TX_DATA_ADDR, 32'h99);
		idle();
		rdc(SPF_RX_DATA_ADDR, 32'h99);
		// slave mode, byte clocked in by the peer at 400 ns
		wr(SPF_CTRL_ADDR, 32'h0201);
		u_peer.send(8'hC5);
		repeat (20) @(posedge clk_in);
		rdc(SPF_RX_DATA_ADDR, 32'hC5);
		// empty tx fifo as slave: the last byte sent goes out again
		chk({24'h0, u_peer.got}, 32'h99);
		stop_test();
	end
endmodule
